// ===== core/bstap_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_ctl (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic                          CE,
  bstap_if.ctl                               LINK,
  input  wire logic                          TEST_EN,
  input  wire logic                          CMD_VALID,
  output logic                               CMD_READY,
  input  wire logic                          CMD_IR,
  input  wire logic [bstap_pkg::LEN_W-1:0]   CMD_LEN,
  input  wire logic [bstap_pkg::CMD_W-1:0]   CMD_DATA,
  output logic                               RSP_VALID,
  output logic      [bstap_pkg::CMD_W-1:0]   RSP_DATA,
  output logic      [bstap_pkg::RAM_AW-1:0]  PROM_ADDR,
  input  wire logic [bstap_pkg::RAM_DW-1:0]  PROM_WORD
);
  import bstap_pkg::*;

  typedef enum logic [2:0] {C_OFF, C_RST, C_IDLE, C_HEAD, C_SHIFT, C_TAIL} bstap_ph_e;

  typedef struct packed {
    bstap_ph_e          ph;
    logic               te;
    logic [DIV_W-1:0]   div;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic               smp;
    logic               fin;
    logic [HC_W-1:0]    hcnt;
    logic [HC_W-1:0]    hlen;
    logic [3:0]         hd;
    logic [LEN_W-1:0]   len;
    logic [LEN_W-1:0]   bcnt;
    logic [CMD_W-1:0]   sh;
    logic [CMD_W-1:0]   rsp;
    logic               rsp_v;
    logic [CMD_W-1:0]   rsp_d;
    logic               tdo_a;
    logic               tdo_b;
    logic               tdo_c;
    logic               rro_a;
    logic               rro_b;
    logic [RAM_AW-1:0]  paddr;
    logic [BIT_W-1:0]   pbit;
  } bstap_ctl_s;

  bstap_ctl_s c_r;
  bstap_ctl_s c_nxt;

  assign CMD_READY = (c_r.ph == C_IDLE) && !c_r.tck;

  always_comb begin
    c_nxt       = c_r;
    c_nxt.te    = TEST_EN;
    c_nxt.tdo_a = LINK.tdo;
    c_nxt.tdo_b = c_r.tdo_a;
    c_nxt.tdo_c = c_r.tdo_b;
    c_nxt.rro_a = LINK.trst_n;
    c_nxt.rro_b = c_r.rro_a;
    c_nxt.rsp_v = 1'b0;
    if (!c_r.te) begin
      // Quiet link: clock parked, mode select high, data carries PROM
      c_nxt.ph  = C_OFF;
      c_nxt.tck = 1'b0;
      c_nxt.tms = 1'b1;
      c_nxt.div = '0;
      c_nxt.fin = 1'b0;
      c_nxt.smp = 1'b0;
      if (!c_r.rro_b) begin
        c_nxt.paddr = '0;
        c_nxt.pbit  = '0;
        c_nxt.tdi   = 1'b1;
      end else if (c_r.tdo_b && !c_r.tdo_c) begin
        c_nxt.tdi  = PROM_WORD[c_r.pbit];
        c_nxt.pbit = c_r.pbit + 3'h1;
        if (c_r.pbit == BIT_LAST) begin
          c_nxt.paddr = c_r.paddr + 4'h1;
        end
      end
    end else if (c_r.ph == C_OFF) begin
      c_nxt.ph   = C_RST;
      c_nxt.tms  = 1'b1;
      c_nxt.tdi  = 1'b1;
      c_nxt.hcnt = 3'h1;
    end else if (CMD_READY && CMD_VALID) begin
      c_nxt.ph   = C_HEAD;
      c_nxt.hd   = CMD_IR ? HEAD_IR : HEAD_DR;
      c_nxt.hlen = CMD_IR ? HEAD_IR_LEN : HEAD_DR_LEN;
      c_nxt.tms  = CMD_IR ? HEAD_IR[0] : HEAD_DR[0];
      c_nxt.hcnt = 3'h1;
      c_nxt.len  = (CMD_LEN == '0) ? 6'h01 : CMD_LEN;
      c_nxt.bcnt = '0;
      c_nxt.sh   = CMD_DATA;
      c_nxt.rsp  = '0;
    end else if ((c_r.ph != C_IDLE) || c_r.tck) begin
      c_nxt.div = c_r.div + 4'h1;
      if (c_r.div == TCK_HALF - 4'h1) begin
        c_nxt.div = '0;
        c_nxt.tck = ~c_r.tck;
        if (!c_r.tck) begin
          // Rising edge: the device samples, we take its output bit
          if (c_r.smp) begin
            c_nxt.rsp = {c_r.tdo_b, c_r.rsp[CMD_W-1:1]};
            c_nxt.smp = 1'b0;
          end
          if (c_r.fin) begin
            c_nxt.fin = 1'b0;
            if (c_r.ph == C_TAIL) begin
              c_nxt.rsp_v = 1'b1;
              c_nxt.rsp_d = c_r.rsp >> (CMD_W - int'(c_r.len));
            end
            c_nxt.ph = C_IDLE;
          end
        end else begin
          // Falling edge: present the next mode and data bits
          case (c_r.ph)
            C_RST: begin
              c_nxt.hcnt = c_r.hcnt + 3'h1;
              c_nxt.tms  = (c_r.hcnt != RST_LEN);
              c_nxt.fin  = (c_r.hcnt == RST_LEN);
            end
            C_HEAD, C_SHIFT: begin
              if ((c_r.ph == C_HEAD) && (c_r.hcnt != c_r.hlen)) begin
                c_nxt.tms  = c_r.hd[c_r.hcnt[1:0]];
                c_nxt.hcnt = c_r.hcnt + 3'h1;
              end else if (c_r.bcnt == c_r.len) begin
                c_nxt.ph  = C_TAIL;
                c_nxt.tms = 1'b1;
              end else begin
                c_nxt.ph   = C_SHIFT;
                c_nxt.tdi  = c_r.sh[0];
                c_nxt.sh   = c_r.sh >> 1;
                c_nxt.tms  = (c_r.bcnt == c_r.len - 6'h01);
                c_nxt.bcnt = c_r.bcnt + 6'h01;
                c_nxt.smp  = 1'b1;
              end
            end
            C_TAIL: begin
              if (!c_r.fin && c_r.tms) begin
                c_nxt.tms = 1'b0;
                c_nxt.fin = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      // Output syncs start at the released level of the data pin, so no
      // false PROM clock edge follows reset
      c_r <= '{ph: C_OFF, tms: 1'b1, tdi: 1'b1, tdo_a: 1'b1, tdo_b: 1'b1,
               tdo_c: 1'b1, default: '0};
    end else if (CE) begin
      c_r <= c_nxt;
    end
  end

  assign LINK.tck         = c_r.tck;
  assign LINK.tms         = c_r.tms;
  assign LINK.tdi         = c_r.tdi;
  assign LINK.special_test_select         = 1'b0;
  assign LINK.trst_ctl_o  = 1'b1;
  // Off-test the pin is released to the board pull-down
  assign LINK.trst_ctl_oe = c_r.te;
  assign RSP_VALID        = c_r.rsp_v;
  assign RSP_DATA         = c_r.rsp_d;
  assign PROM_ADDR        = c_r.paddr;

endmodule : bstap_ctl
`default_nettype wire

// ===== core/bstap_dev.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_dev (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic                          CE,
  bstap_if.dev                               LINK,
  input  wire logic [bstap_pkg::N_PIN-1:0]   PIN_IN,
  input  wire logic [bstap_pkg::N_PIN-1:0]   CORE_OUT,
  output logic      [bstap_pkg::N_PIN-1:0]   PIN_OUT,
  input  wire logic                          INIT_START,
  output logic                               INIT_BUSY,
  output logic                               INIT_DONE,
  output logic                               RAM_WE,
  output logic      [bstap_pkg::RAM_AW-1:0]  RAM_ADDR,
  output logic      [bstap_pkg::RAM_DW-1:0]  RAM_DATA,
  output logic                               SPECIAL_TEST
);
  import bstap_pkg::*;

  // ************************************************************
  // Test clock domain state
  // ************************************************************
  typedef struct packed {
    bstap_tap_e         st;
    bstap_ir_t          ir;
    bstap_ir_t          ir_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               byp;
    logic               upd_tgl;
    logic               ext;
    logic [BSR_LEN-1:0] smp_a;
    logic [BSR_LEN-1:0] smp_b;
  } bstap_tap_s;

  localparam bstap_tap_s TAP_RST = '{st: TLR, ir: OP_BYPASS, default: '0};

  // Boundary register is selected only by the two boundary opcodes;
  // every other code, user ones included, falls through to bypass
  function automatic logic ir_is_bsr(input bstap_ir_t ir);
    ir_is_bsr = (ir == OP_EXTEST) || (ir == OP_SAMPLE);
  endfunction : ir_is_bsr

  bstap_tap_s t_r;
  bstap_tap_s t_nxt;
  logic       tdo_r;
  logic       tdo_oe_r;

  always_comb begin
    t_nxt       = t_r;
    // Snapshot of async pins and core outputs, two stages before use
    t_nxt.smp_a = {CORE_OUT, PIN_IN};
    t_nxt.smp_b = t_r.smp_a;
    t_nxt.st    = bstap_next(t_r.st, LINK.tms);
    case (t_r.st)
      TLR: begin
        t_nxt.ir = OP_BYPASS;
      end
      CIR: begin
        t_nxt.ir_sh = IR_CAPT;
      end
      SHIR: begin
        t_nxt.ir_sh = {LINK.tdi, t_r.ir_sh[IR_W-1:1]};
      end
      UIR: begin
        t_nxt.ir = t_r.ir_sh;
      end
      CDR: begin
        if (t_r.ir == OP_EXTEST) begin
          // Output cells report what they drive, input cells the pins
          t_nxt.bsr_sh = {t_r.bsr_upd[BSR_LEN-1:N_PIN], t_r.smp_b[N_PIN-1:0]};
        end else if (t_r.ir == OP_SAMPLE) begin
          t_nxt.bsr_sh = t_r.smp_b;
        end else begin
          t_nxt.byp = 1'b0;
        end
      end
      SHDR: begin
        if (ir_is_bsr(t_r.ir)) begin
          t_nxt.bsr_sh = {LINK.tdi, t_r.bsr_sh[BSR_LEN-1:1]};
        end else begin
          t_nxt.byp = LINK.tdi;
        end
      end
      UDR: begin
        // Preload lands here and stays until the next update
        if (ir_is_bsr(t_r.ir)) begin
          t_nxt.bsr_upd = t_r.bsr_sh;
          t_nxt.upd_tgl = ~t_r.upd_tgl;
        end
      end
      default: begin
      end
    endcase
    // Follows the new instruction at once: the test clock parks after
    // update-IR, so a lagging copy would leave the pins in function
    t_nxt.ext = (t_nxt.ir == OP_EXTEST);
  end

  always_ff @(posedge LINK.tck or negedge LINK.trst_n) begin
    if (!LINK.trst_n) begin
      t_r <= TAP_RST;
    end else begin
      t_r <= t_nxt;
    end
  end

  // Serial output moves on the falling edge so the far end samples
  // a settled bit on the next rising edge
  always_ff @(negedge LINK.tck or negedge LINK.trst_n) begin
    if (!LINK.trst_n) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_oe_r <= (t_r.st == SHIR) || (t_r.st == SHDR);
      if (t_r.st == SHIR) begin
        tdo_r <= t_r.ir_sh[0];
      end else if (ir_is_bsr(t_r.ir)) begin
        tdo_r <= t_r.bsr_sh[0];
      end else begin
        tdo_r <= t_r.byp;
      end
    end
  end

  // ************************************************************
  // System clock domain state
  // ************************************************************
  typedef enum logic [1:0] {I_IDLE, I_RST, I_HI, I_LO} bstap_init_e;

  typedef struct packed {
    logic               ext_a;
    logic               ext_b;
    logic               tgl_a;
    logic               tgl_b;
    logic               tgl_c;
    logic [N_PIN-1:0]   drv;
    logic [N_PIN-1:0]   pin_out;
    logic               tdi_a;
    logic               tdi_b;
    logic               stm_a;
    logic               stm_b;
    bstap_init_e        ist;
    logic [CNT_W-1:0]   cnt;
    logic [BIT_W-1:0]   bcnt;
    logic [RAM_AW-1:0]  addr;
    logic [RAM_DW-1:0]  word;
    logic               we;
    logic [RAM_AW-1:0]  we_addr;
    logic               done;
    logic               ram_init_clock_out;
    logic               ram_init_reset_out;
  } bstap_sys_s;

  bstap_sys_s s_r;
  bstap_sys_s s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.ext_a = t_r.ext;
    s_nxt.ext_b = s_r.ext_a;
    s_nxt.tgl_a = t_r.upd_tgl;
    s_nxt.tgl_b = s_r.tgl_a;
    s_nxt.tgl_c = s_r.tgl_b;
    s_nxt.tdi_a = LINK.tdi;
    s_nxt.tdi_b = s_r.tdi_a;
    s_nxt.stm_a = LINK.special_test_select;
    s_nxt.stm_b = s_r.stm_a;
    s_nxt.we    = 1'b0;
    // The update word changes with its toggle and then holds; the toggle
    // needs two system clocks to arrive, so the word is settled by then
    if (s_r.tgl_b != s_r.tgl_c) begin
      s_nxt.drv = t_r.bsr_upd[BSR_LEN-1:N_PIN];
    end
    // Function drives the pins unless extest is in force
    s_nxt.pin_out = s_r.ext_b ? s_r.drv : CORE_OUT;
    s_nxt.cnt     = s_r.cnt + 8'h01;
    case (s_r.ist)
      I_IDLE: begin
        s_nxt.cnt = '0;
        if (INIT_START) begin
          s_nxt.ist  = I_RST;
          s_nxt.ram_init_reset_out  = 1'b0;
          s_nxt.ram_init_clock_out  = 1'b0;
          s_nxt.done = 1'b0;
          s_nxt.addr = '0;
          s_nxt.bcnt = '0;
        end
      end
      I_RST: begin
        if (s_r.cnt == PROM_RST_CYC - 8'h01) begin
          s_nxt.ist = I_HI;
          s_nxt.cnt = '0;
          s_nxt.ram_init_reset_out = 1'b1;
          s_nxt.ram_init_clock_out = 1'b1;
        end
      end
      I_HI: begin
        if (s_r.cnt == PROM_HALF - 8'h01) begin
          s_nxt.ist = I_LO;
          s_nxt.cnt = '0;
          s_nxt.ram_init_clock_out = 1'b0;
        end
      end
      I_LO: begin
        if (s_r.cnt == PROM_HALF - 8'h01) begin
          s_nxt.cnt  = '0;
          s_nxt.word = {s_r.tdi_b, s_r.word[RAM_DW-1:1]};
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          s_nxt.ist  = I_HI;
          s_nxt.ram_init_clock_out  = 1'b1;
          if (s_r.bcnt == BIT_LAST) begin
            s_nxt.we      = 1'b1;
            s_nxt.we_addr = s_r.addr;
            s_nxt.addr    = s_r.addr + 4'h1;
            if (s_r.addr == ADDR_LAST) begin
              s_nxt.ist  = I_IDLE;
              s_nxt.ram_init_clock_out  = 1'b0;
              s_nxt.done = 1'b1;
            end
          end
        end
      end
      default: begin
        s_nxt.ist = I_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign INIT_BUSY    = (s_r.ist != I_IDLE);
  assign INIT_DONE    = s_r.done;
  assign RAM_WE       = s_r.we;
  assign RAM_ADDR     = s_r.we_addr;
  assign RAM_DATA     = s_r.word;
  assign PIN_OUT      = s_r.pin_out;
  assign SPECIAL_TEST = s_r.stm_b;

  // Shared pins turn into PROM clock and reset while loading
  assign LINK.tdo_o       = INIT_BUSY ? s_r.ram_init_clock_out : tdo_r;
  assign LINK.tdo_oe      = INIT_BUSY | tdo_oe_r;
  assign LINK.trst_dev_o  = s_r.ram_init_reset_out;
  assign LINK.trst_dev_oe = INIT_BUSY;

endmodule : bstap_dev
`default_nettype wire

// ===== core/bstap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bstap_if;

  logic tck;
  logic tms;
  logic tdi;
  logic special_test_select;
  logic tdo_o;
  logic tdo_oe;
  logic trst_dev_o;
  logic trst_dev_oe;
  logic trst_ctl_o;
  logic trst_ctl_oe;
  logic tdo;
  logic trst_n;

  // ************************************************************
  // Wire resolution
  // ************************************************************
  // Undriven reset pin sits on the board pull-down
  assign trst_n = trst_dev_oe ? trst_dev_o : (trst_ctl_oe ? trst_ctl_o : 1'b0);
  assign tdo    = tdo_oe ? tdo_o : 1'b1;

  modport dev (
    input  tck, tms, tdi, special_test_select, trst_n,
    output tdo_o, tdo_oe, trst_dev_o, trst_dev_oe
  );

  modport ctl (
    output tck, tms, tdi, special_test_select, trst_ctl_o, trst_ctl_oe,
    input  tdo, trst_n
  );

endinterface : bstap_if
`default_nettype wire

// ===== core/bstap_pkg.sv
// Operation
// - Extest drives pins from boundary register
// - Extest input cells capture pin values
// - Preloaded boundary values held until extest
// - Sample keeps functional mode, boundary in path
// - Sample captures pin and core snapshots
// - Bypass routes data through one-bit register
// - Bypass shifting leaves function undisturbed
// - Instructions selected through instruction register
// - Active-low test reset clears TAP
// - Test reset held low outside test, except while the device loads the PROM
// - Data and mode inputs high outside test, except data while the PROM loads
// - Test clock static outside test
// - Serial PROM data enters on data input
// - Data output pin clocks serial PROM
// - Test reset pin resets serial PROM
// - Special test select tied low
package bstap_pkg;

  // ************************************************************
  // Scan geometry and opcodes
  // ************************************************************
  localparam int N_PIN   = 8;
  localparam int IR_W    = 4;
  localparam int BSR_LEN = 2 * N_PIN;

  typedef logic [IR_W-1:0] bstap_ir_t;

  localparam bstap_ir_t OP_EXTEST = 4'h0;
  localparam bstap_ir_t OP_SAMPLE = 4'h1;
  localparam bstap_ir_t OP_BYPASS = 4'hF;
  // Fixed low bits 01 loaded into the instruction shifter on capture
  localparam bstap_ir_t IR_CAPT   = 4'h1;

  // ************************************************************
  // RAM initialisation from serial PROM
  // ************************************************************
  localparam int RAM_AW = 4;
  localparam int RAM_DW = 8;
  localparam int CNT_W  = 8;
  localparam int BIT_W  = 3;

  localparam logic [CNT_W-1:0]  PROM_HALF    = 8'h08;
  localparam logic [CNT_W-1:0]  PROM_RST_CYC = 8'h10;
  localparam logic [BIT_W-1:0]  BIT_LAST     = 3'h7;
  localparam logic [RAM_AW-1:0] ADDR_LAST    = 4'hF;

  // ************************************************************
  // Test controller end
  // ************************************************************
  localparam int CMD_W = 32;
  localparam int LEN_W = 6;
  localparam int DIV_W = 4;
  localparam int HC_W  = 3;

  localparam logic [DIV_W-1:0] TCK_HALF    = 4'h4;
  localparam logic [HC_W-1:0]  HEAD_IR_LEN = 3'h4;
  localparam logic [HC_W-1:0]  HEAD_DR_LEN = 3'h3;
  localparam logic [HC_W-1:0]  RST_LEN     = 3'h5;
  // Mode-select patterns from Run-Test/Idle to Shift, first bit in bit 0
  localparam logic [3:0]       HEAD_IR     = 4'h3;
  localparam logic [3:0]       HEAD_DR     = 4'h1;

  // ************************************************************
  // TAP state machine
  // ************************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SDR, CDR, SHDR, E1DR, PDR, E2DR, UDR,
    SIR, CIR, SHIR, E1IR, PIR, E2IR, UIR
  } bstap_tap_e;

  function automatic bstap_tap_e bstap_next(input bstap_tap_e s, input logic tms);
    case (s)
      TLR:     bstap_next = tms ? TLR  : RTI;
      RTI:     bstap_next = tms ? SDR  : RTI;
      SDR:     bstap_next = tms ? SIR  : CDR;
      CDR:     bstap_next = tms ? E1DR : SHDR;
      SHDR:    bstap_next = tms ? E1DR : SHDR;
      E1DR:    bstap_next = tms ? UDR  : PDR;
      PDR:     bstap_next = tms ? E2DR : PDR;
      E2DR:    bstap_next = tms ? UDR  : SHDR;
      UDR:     bstap_next = tms ? SDR  : RTI;
      SIR:     bstap_next = tms ? TLR  : CIR;
      CIR:     bstap_next = tms ? E1IR : SHIR;
      SHIR:    bstap_next = tms ? E1IR : SHIR;
      E1IR:    bstap_next = tms ? UIR  : PIR;
      PIR:     bstap_next = tms ? E2IR : PIR;
      E2IR:    bstap_next = tms ? UIR  : SHIR;
      UIR:     bstap_next = tms ? SDR  : RTI;
      default: bstap_next = TLR;
    endcase
  endfunction : bstap_next

endpackage : bstap_pkg

// ===== verif/bstap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_asserts (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic special_test_select,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic trst_dev_o,
  input wire logic trst_dev_oe,
  input wire logic trst_ctl_oe,
  input wire logic trst_n
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // ********************
  // Sequences
  // ********************
  sequence s_rst_low;
    !trst_dev_o throughout (1'b1 ##15 1'b1);
  endsequence
  sequence s_rco_high;
    tdo_o [*8];
  endsequence
  // Four cycles leave room for the release of the reset pin to settle
  sequence s_trst_held;
    (!trst_n && !trst_dev_oe) [*4];
  endsequence

  // ********************
  // Properties
  // ********************
  property p_tck_high;
    $rose(tck) |-> tck [*4] ##1 !tck;
  endproperty
  property p_drive_on_fall;
    $changed(tms) || $changed(tdi) |-> !tck;
  endproperty
  property p_trst_clears;
    s_trst_held |-> !tdo_oe;
  endproperty
  property p_one_trst_driver;
    !(trst_dev_oe && trst_ctl_oe);
  endproperty
  property p_prom_rst;
    $rose(trst_dev_oe) |-> s_rst_low ##1 trst_dev_o;
  endproperty
  property p_prom_clk;
    trst_dev_oe && tdo_oe && $rose(tdo_o) |-> s_rco_high ##1 !tdo_o;
  endproperty
  property p_tck_static;
    !trst_n |-> $stable(tck);
  endproperty
  property p_stm_low;
    !special_test_select;
  endproperty
  // PROM data may only move while its clock is high
  property p_prom_data;
    trst_dev_oe && trst_n && $changed(tdi) |-> tdo_o;
  endproperty

  a_tck_high: assert property (p_tck_high)
    else $error("test clock high phase length wrong");
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("mode or data input moved while test clock high");
  a_trst_clears: assert property (p_trst_clears)
    else $error("data output enabled while test reset low");
  a_one_trst_driver: assert property (p_one_trst_driver)
    else $error("reset pin driven by both ends");
  a_prom_rst: assert property (p_prom_rst)
    else $error("PROM reset pulse length wrong");
  a_prom_clk: assert property (p_prom_clk)
    else $error("PROM clock high phase length wrong");
  a_tck_static: assert property (p_tck_static)
    else $error("test clock toggled outside test");
  a_stm_low: assert property (p_stm_low)
    else $error("special test select not low");
  a_prom_data: assert property (p_prom_data)
    else $error("PROM data moved while its clock low");
endmodule : bstap_asserts
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bstap_pkg::*;
  logic              clk;
  logic              nrst;
  logic              test_en;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              cmd_ir;
  logic [LEN_W-1:0]  cmd_len;
  logic [CMD_W-1:0]  cmd_data;
  logic              rsp_valid;
  logic [CMD_W-1:0]  rsp_data;
  logic [RAM_AW-1:0] prom_addr;
  logic [RAM_DW-1:0] prom_word;
  logic [N_PIN-1:0]  pin_in;
  logic [N_PIN-1:0]  core_out;
  logic [N_PIN-1:0]  pin_out;
  logic              init_start;
  logic              init_busy;
  logic              init_done;
  logic              ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [RAM_DW-1:0] ram_data;
  logic              special_test;
  logic [CMD_W-1:0]  r;
  int                fail_count;
  int                check_count;

  // ********************
  // Structure
  // ********************
  bstap_if u_bstap_if ();
  bstap_dev u_bstap_dev (.CLK(clk), .NRST(nrst), .CE(1'b1), .LINK(u_bstap_if.dev),
    .PIN_IN(pin_in), .CORE_OUT(core_out), .PIN_OUT(pin_out), .INIT_START(init_start),
    .INIT_BUSY(init_busy), .INIT_DONE(init_done), .RAM_WE(ram_we), .RAM_ADDR(ram_addr),
    .RAM_DATA(ram_data), .SPECIAL_TEST(special_test));
  bstap_ctl u_bstap_ctl (.CLK(clk), .NRST(nrst), .CE(1'b1), .LINK(u_bstap_if.ctl),
    .TEST_EN(test_en), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_IR(cmd_ir),
    .CMD_LEN(cmd_len), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .PROM_ADDR(prom_addr), .PROM_WORD(prom_word));
  bstap_asserts u_bstap_asserts (.CLK(clk), .NRST(nrst), .tck(u_bstap_if.tck),
    .tms(u_bstap_if.tms), .tdi(u_bstap_if.tdi), .special_test_select(u_bstap_if.special_test_select),
    .tdo_o(u_bstap_if.tdo_o), .tdo_oe(u_bstap_if.tdo_oe),
    .trst_dev_o(u_bstap_if.trst_dev_o), .trst_dev_oe(u_bstap_if.trst_dev_oe),
    .trst_ctl_oe(u_bstap_if.trst_ctl_oe), .trst_n(u_bstap_if.trst_n));

  // PROM contents differ in every bit position across words
  function automatic logic [RAM_DW-1:0] prom_val(input int a);
    return RAM_DW'(a * 37 + 11);
  endfunction : prom_val
  assign prom_word = prom_val(int'(prom_addr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input string nm, input logic [CMD_W-1:0] e, input logic [CMD_W-1:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic scan(input logic ir, input int len, input logic [CMD_W-1:0] d,
                      output logic [CMD_W-1:0] q);
    cmd_valid <= 1'b1;
    cmd_ir    <= ir;
    cmd_len   <= LEN_W'(len);
    cmd_data  <= d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1);
    q = rsp_data & ((32'h1 << len) - 32'h1);
  endtask : scan

  task automatic ir_load(input bstap_ir_t op);
    logic [CMD_W-1:0] q;
    scan(1'b1, IR_W, CMD_W'(op), q);
    chk("ir_capture", CMD_W'(IR_CAPT), q);
  endtask : ir_load

  task automatic ram_init;
    init_start <= 1'b1;
    @(posedge clk);
    init_start <= 1'b0;
    repeat (24) @(posedge clk);
    chk("prom_reset_end", 32'h1, CMD_W'(u_bstap_if.trst_n));
    chk("init_busy", 32'h1, CMD_W'(init_busy));
    chk("init_done_early", 32'h0, CMD_W'(init_done));
    for (int k = 0; k < 16; k++) begin
      do @(posedge clk); while (ram_we !== 1'b1);
      chk("ram_addr", CMD_W'(k), CMD_W'(ram_addr));
      chk("ram_data", CMD_W'(prom_val(k)), CMD_W'(ram_data));
    end
    do @(posedge clk); while (init_done !== 1'b1);
    chk("init_idle", 32'h0, CMD_W'(init_busy));
  endtask : ram_init

  // ********************
  // Sequence of tests
  // ********************
  initial begin
    nrst = 1'b0;
    test_en = 1'b0;
    cmd_valid = 1'b0;
    cmd_ir = 1'b0;
    cmd_len = '0;
    cmd_data = '0;
    pin_in = 8'h3E;
    core_out = 8'h96;
    init_start = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    chk("trst_idle", 32'h0, CMD_W'(u_bstap_if.trst_n));
    chk("special", 32'h0, CMD_W'(special_test));
    chk("tms_idle", 32'h1, CMD_W'(u_bstap_if.tms));
    chk("tdi_idle", 32'h1, CMD_W'(u_bstap_if.tdi));
    test_en <= 1'b1;
    ir_load(OP_BYPASS);
    scan(1'b0, 8, 32'h0000_00A5, r);
    chk("bypass_dr", 32'h0000_004A, r);
    chk("pin_out_bypass", 32'h0000_0096, CMD_W'(pin_out));
    ir_load(4'h7);
    scan(1'b0, 8, 32'h0000_00C3, r);
    chk("unknown_dr", 32'h0000_0086, r);
    ir_load(OP_SAMPLE);
    scan(1'b0, BSR_LEN, 32'h0000_3C00, r);
    chk("sample_dr", 32'h0000_963E, r);
    chk("pin_out_sample", 32'h0000_0096, CMD_W'(pin_out));
    ir_load(OP_EXTEST);
    repeat (8) @(posedge clk);
    chk("pin_out_preload", 32'h0000_003C, CMD_W'(pin_out));
    pin_in <= 8'h71;
    scan(1'b0, BSR_LEN, 32'h0000_A500, r);
    chk("extest_dr", 32'h0000_3C71, r);
    repeat (8) @(posedge clk);
    chk("pin_out_extest", 32'h0000_00A5, CMD_W'(pin_out));
    ir_load(OP_BYPASS);
    repeat (8) @(posedge clk);
    chk("pin_out_function", 32'h0000_0096, CMD_W'(pin_out));
    test_en <= 1'b0;
    repeat (40) @(posedge clk);
    chk("trst_after_test", 32'h0, CMD_W'(u_bstap_if.trst_n));
    chk("tms_after_test", 32'h1, CMD_W'(u_bstap_if.tms));
    chk("tdi_after_test", 32'h1, CMD_W'(u_bstap_if.tdi));
    ram_init();
    results();
  end

  // Whole run needs about 3200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule : testbench
`default_nettype wire
